// >>> sct_defs.svh
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH
// Notes on behaviour
// - All link lines active low, open collector.
// - Initiator asserts select before anything else.
// - Target answers select with busy, holds it.
// - Control/data asserted for control, released for data.
// - Input/output asserted when bytes go to initiator.
// - Target request starts each byte handshake.
// - Initiator acknowledges each request.
// - Reset line clears bus; target abandons everything.
// - Message line marks the completion message byte.
// - One byte per handshake, bit 0 least significant.
// - Host side inverts data both ways.
// - Target buffers one 256-byte sector.
// - Phase code on message, control/data, input/output.
// - Request, acknowledge, request off, acknowledge off.
// - Select honoured only with busy, input/output free.
// - Phase lines settle 450ns, hold past acknowledge.

// Bit positions of the control lines in the link vectors.
`define SCT_SEL 0
`define SCT_BSY 1
`define SCT_CD 2
`define SCT_IO 3
`define SCT_REQ 4
`define SCT_ACK 5
`define SCT_RST 6
`define SCT_MSG 7

// Timing, clock period in ns.
`define SCT_CLK_NS 8
`define SCT_SETUP_NS 450
`define SCT_SETUP_CYC ((`SCT_SETUP_NS + `SCT_CLK_NS - 1) / `SCT_CLK_NS)
`define SCT_RST_NS 25000
`define SCT_RST_CYC ((`SCT_RST_NS + `SCT_CLK_NS - 1) / `SCT_CLK_NS)

// Transfer sizes and byte values.
`define SCT_CMD_LAST 8'h05
`define SCT_SECT_LAST 8'hff
`define SCT_OP_READ 8'h08
`define SCT_OP_WRITE 8'h0a
`define SCT_MSG_DONE 8'h00
`endif

// >>> sct_initiator.sv
`timescale 1ns/1ps
`include "sct_defs.svh"
module sct_initiator (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    sct_link_if.initiator link,
    input wire logic start_in,
    input wire logic rst_req_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [2:0] phase_out,
    output logic busy_out,
    output logic done_out
);
    ////////////////////////////////////////////////////////////////////////
    // Observed line levels, asserted-high.
    logic sel_a;
    logic bsy_a;
    logic io_a;
    logic req_a;
    logic rst_a;

    assign sel_a = ~link.ctl_n[`SCT_SEL];
    assign bsy_a = ~link.ctl_n[`SCT_BSY];
    assign io_a = ~link.ctl_n[`SCT_IO];
    assign req_a = ~link.ctl_n[`SCT_REQ];
    assign rst_a = ~link.ctl_n[`SCT_RST];

    sct_pkg::sct_istate_t state_r;
    logic [11:0] rst_cnt_r;
    logic [7:0] tx_r;
    logic out_r;

    // Outbound byte is accepted only while the target asks for one.
    assign tx_ready_out = (state_r == sct_pkg::SCT_I_XFER) && req_a && !io_a;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer. Power-up starts by driving the link reset.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= sct_pkg::SCT_I_RST;
            rst_cnt_r <= 12'(`SCT_RST_CYC - 1);
        end else if (rst_req_in) begin
            state_r <= sct_pkg::SCT_I_RST;
            rst_cnt_r <= 12'(`SCT_RST_CYC - 1);
        end else begin
            case (state_r)
                sct_pkg::SCT_I_RST: begin
                    if (rst_cnt_r == 12'h000) begin
                        state_r <= sct_pkg::SCT_I_IDLE;
                    end else begin
                        rst_cnt_r <= rst_cnt_r - 12'h001;
                    end
                end
                sct_pkg::SCT_I_IDLE: begin
                    // Bus free: select, busy and reset all released.
                    if (start_in && !sel_a && !bsy_a && !rst_a) begin
                        state_r <= sct_pkg::SCT_I_SEL;
                    end
                end
                sct_pkg::SCT_I_SEL: begin
                    if (bsy_a) begin
                        state_r <= sct_pkg::SCT_I_XFER;
                    end
                end
                sct_pkg::SCT_I_XFER: begin
                    if (!bsy_a) begin
                        state_r <= sct_pkg::SCT_I_IDLE;
                    end else if (req_a && (io_a ? rx_ready_in : tx_valid_in)) begin
                        state_r <= sct_pkg::SCT_I_ACK;
                    end
                end
                sct_pkg::SCT_I_ACK: begin
                    if (!req_a) begin
                        state_r <= sct_pkg::SCT_I_XFER;
                    end
                end
                default: state_r <= sct_pkg::SCT_I_IDLE;
            endcase
        end
    end

    // Byte capture both ways; the link carries data inverted.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_r <= 8'h00;
            out_r <= 1'b0;
            rx_data_out <= 8'h00;
            rx_valid_out <= 1'b0;
            phase_out <= 3'h7;
        end else begin
            rx_valid_out <= 1'b0;
            if (state_r == sct_pkg::SCT_I_XFER && bsy_a && !rst_req_in && req_a) begin
                phase_out <= {link.ctl_n[`SCT_MSG], link.ctl_n[`SCT_CD], link.ctl_n[`SCT_IO]};
                if (io_a && rx_ready_in) begin
                    rx_data_out <= ~link.db_n;
                    rx_valid_out <= 1'b1;
                    out_r <= 1'b0;
                end else if (!io_a && tx_valid_in) begin
                    tx_r <= tx_data_in;
                    out_r <= 1'b1;
                end
            end
        end
    end

    // Done pulse when the target frees the bus after a transfer.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= !rst_req_in && state_r == sct_pkg::SCT_I_XFER && !bsy_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open collector drivers: value low, enable high to assert.
    assign link.ini_ctl_out = 8'h00;
    assign link.ini_db_out = 8'h00;

    always_comb begin
        link.ini_ctl_oe = 8'h00;
        link.ini_ctl_oe[`SCT_RST] = (state_r == sct_pkg::SCT_I_RST);
        link.ini_ctl_oe[`SCT_SEL] = (state_r == sct_pkg::SCT_I_SEL);
        link.ini_ctl_oe[`SCT_ACK] = (state_r == sct_pkg::SCT_I_ACK);
    end

    // A one bit pulls its line low, which is the inversion on the way out.
    assign link.ini_db_oe = (state_r == sct_pkg::SCT_I_ACK && out_r && !io_a) ? tx_r : 8'h00;

    assign busy_out = (state_r != sct_pkg::SCT_I_IDLE);
endmodule

// >>> sct_link_asserts.sv
`timescale 1ns/1ps
`include "sct_defs.svh"
module sct_link_asserts (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] ctl_n,
    input wire logic [7:0] tgt_ctl_out,
    input wire logic [7:0] tgt_ctl_oe,
    input wire logic [7:0] ini_ctl_out,
    input wire logic [7:0] tgt_db_out,
    input wire logic [7:0] tgt_db_oe,
    input wire logic [7:0] ini_db_out,
    input wire logic [7:0] ini_db_oe
);
    logic [2:0] phs_r;
    logic [5:0] stab_r;
    wire [2:0] phs = {ctl_n[`SCT_MSG], ctl_n[`SCT_CD], ctl_n[`SCT_IO]};

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    ////////////////////////////////////////////////////////////////////////
    // Count cycles since the phase lines last moved; it saturates rather than wraps.
    // Data out has the idle levels, so that phase restarts the count only on its change.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phs_r <= 3'h7;
            stab_r <= 6'h00;
        end else begin
            phs_r <= phs;
            stab_r <= (phs != phs_r) ? 6'h00 : (stab_r == 6'h3f ? stab_r : stab_r + 6'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link relations that the two ends must keep between them.
    a_open_coll: assert property ((tgt_ctl_out | ini_ctl_out | tgt_db_out | ini_db_out) == 8'h00)
        else $error("a line is driven high");
    a_sel_gets_bsy: assert property ($fell(ctl_n[`SCT_SEL]) && ctl_n[`SCT_BSY] && ctl_n[`SCT_IO]
        |-> ##[1:2] !ctl_n[`SCT_BSY]) else $error("selection not answered with busy");
    a_bsy_cause: assert property ($rose(tgt_ctl_oe[`SCT_BSY]) |-> !$past(ctl_n[`SCT_SEL]))
        else $error("busy raised without select");
    a_req_ack_drop: assert property ($fell(ctl_n[`SCT_ACK]) && ctl_n[`SCT_RST]
        |-> ##[1:2] ctl_n[`SCT_REQ]) else $error("request held after acknowledge");
    a_req_after_ack: assert property ($fell(ctl_n[`SCT_REQ]) |-> ctl_n[`SCT_ACK])
        else $error("request raised while acknowledge asserted");
    a_setup_time: assert property ($fell(ctl_n[`SCT_REQ]) |-> stab_r >= 6'h38)
        else $error("phase lines not settled before request");
    a_phase_hold: assert property ((!ctl_n[`SCT_REQ] || !ctl_n[`SCT_ACK]) && ctl_n[`SCT_RST]
        && $past(ctl_n[`SCT_RST]) |-> $stable(phs)) else $error("phase moved during handshake");
    a_phase_code: assert property (!ctl_n[`SCT_REQ] |-> phs inside {3'h7, 3'h6, 3'h5, 3'h4, 3'h0})
        else $error("illegal phase code");
    a_tgt_db_dir: assert property (tgt_db_oe != 8'h00 |-> !ctl_n[`SCT_IO])
        else $error("target drives data while outbound");
    a_ini_db_dir: assert property (ini_db_oe != 8'h00 |-> ctl_n[`SCT_IO] && !ctl_n[`SCT_ACK])
        else $error("initiator drives data out of turn");
    a_rst_clears: assert property (!ctl_n[`SCT_RST] |-> tgt_ctl_oe == 8'h00 && tgt_db_oe == 8'h00)
        else $error("target still drives during reset");
    a_bsy_release: assert property ($rose(ctl_n[`SCT_ACK]) && !ctl_n[`SCT_MSG] && ctl_n[`SCT_RST]
        |-> ##[1:2] ctl_n[`SCT_BSY] && phs == 3'h7) else $error("bus not freed after message");
    a_sel_first: assert property ($fell(ctl_n[`SCT_SEL]) |-> (ctl_n | 8'h01) == 8'hff)
        else $error("select was not the first action");
    a_ack_answers: assert property ($fell(ctl_n[`SCT_ACK]) |-> !$past(ctl_n[`SCT_REQ]))
        else $error("acknowledge without request");
endmodule

// >>> sct_link_if.sv
`timescale 1ns/1ps
interface sct_link_if;
    logic [7:0] tgt_ctl_out;
    logic [7:0] tgt_ctl_oe;
    logic [7:0] ini_ctl_out;
    logic [7:0] ini_ctl_oe;
    logic [7:0] tgt_db_out;
    logic [7:0] tgt_db_oe;
    logic [7:0] ini_db_out;
    logic [7:0] ini_db_oe;
    logic [7:0] ctl_n;
    logic [7:0] db_n;

    // Wired-AND: a line is low when any enabled driver pulls it low.
    assign ctl_n = ~((tgt_ctl_oe & ~tgt_ctl_out) | (ini_ctl_oe & ~ini_ctl_out));
    assign db_n = ~((tgt_db_oe & ~tgt_db_out) | (ini_db_oe & ~ini_db_out));

    modport target (
        input ctl_n, db_n,
        output tgt_ctl_out, tgt_ctl_oe, tgt_db_out, tgt_db_oe
    );
    modport initiator (
        input ctl_n, db_n,
        output ini_ctl_out, ini_ctl_oe, ini_db_out, ini_db_oe
    );
endinterface

// >>> sct_pkg.sv
package sct_pkg;
    // Phase code as line levels {msg, cd, io}, 1 = released.
    typedef enum logic [2:0] {
        SCT_PH_DOUT = 3'h7,
        SCT_PH_DIN = 3'h6,
        SCT_PH_CMD = 3'h5,
        SCT_PH_STAT = 3'h4,
        SCT_PH_MSGIN = 3'h0
    } sct_phase_t;

    typedef enum logic [2:0] {
        SCT_T_IDLE = 3'h0,
        SCT_T_SEL = 3'h1,
        SCT_T_SETUP = 3'h3,
        SCT_T_REQ = 3'h2,
        SCT_T_REL = 3'h6
    } sct_tstate_t;

    typedef enum logic [2:0] {
        SCT_I_IDLE = 3'h0,
        SCT_I_RST = 3'h1,
        SCT_I_SEL = 3'h3,
        SCT_I_XFER = 3'h2,
        SCT_I_ACK = 3'h6
    } sct_istate_t;
endpackage

// >>> sct_sector_mem.sv
`timescale 1ns/1ps
module sct_sector_mem (
    input wire logic mclk_in,
    input wire logic we_in,
    input wire logic [7:0] waddr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] raddr_a_in,
    output logic [7:0] rdata_a_out,
    input wire logic [7:0] raddr_b_in,
    output logic [7:0] rdata_b_out
);
    logic [7:0] mem_r [0:255];

    // One write port and two read ports; storage has no reset.
    always_ff @(posedge mclk_in) begin
        if (we_in) begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    assign rdata_a_out = mem_r[raddr_a_in];
    assign rdata_b_out = mem_r[raddr_b_in];
endmodule

// >>> sct_target.sv
`timescale 1ns/1ps
`include "sct_defs.svh"
module sct_target (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    sct_link_if.target link,
    output logic [7:0] cmd_op_out,
    output logic cmd_valid_out,
    input wire logic [7:0] status_in,
    output logic busy_out,
    output logic done_out,
    output logic bus_reset_out,
    input wire logic disc_we_in,
    input wire logic [7:0] disc_addr_in,
    input wire logic [7:0] disc_wdata_in,
    output logic [7:0] disc_rdata_out,
    output logic disc_ready_out
);
    ////////////////////////////////////////////////////////////////////////
    // Observed line levels, turned to asserted-high.
    logic sel_a;
    logic bsy_a;
    logic io_a;
    logic ack_a;
    logic rst_a;
    logic [7:0] rx_byte;

    assign sel_a = ~link.ctl_n[`SCT_SEL];
    assign bsy_a = ~link.ctl_n[`SCT_BSY];
    assign io_a = ~link.ctl_n[`SCT_IO];
    assign ack_a = ~link.ctl_n[`SCT_ACK];
    assign rst_a = ~link.ctl_n[`SCT_RST];
    assign rx_byte = ~link.db_n;

    ////////////////////////////////////////////////////////////////////////
    // State.
    sct_pkg::sct_tstate_t state_r;
    sct_pkg::sct_phase_t phase_r;
    sct_pkg::sct_phase_t phase_nxt;
    logic [7:0] idx_r;
    logic [7:0] last_idx;
    logic [5:0] setup_r;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic [7:0] mem_a;
    logic [7:0] mem_b;
    logic link_we;
    logic to_ini;
    logic in_xfer;
    logic rst_d_r;

    // Input/output is asserted (level 0) for inbound phases.
    assign to_ini = ~phase_r[0];
    assign in_xfer = (state_r == sct_pkg::SCT_T_SETUP) || (state_r == sct_pkg::SCT_T_REQ)
        || (state_r == sct_pkg::SCT_T_REL);

    ////////////////////////////////////////////////////////////////////////
    // Sector buffer shared by the link and the disc side.
    assign link_we = (state_r == sct_pkg::SCT_T_REQ) && ack_a && !rst_a
        && (phase_r == sct_pkg::SCT_PH_DOUT);
    // The link has priority; the disc side must wait while it writes.
    assign disc_ready_out = !link_we;

    sct_sector_mem u_mem (
        .mclk_in(mclk_in),
        .we_in(link_we || disc_we_in),
        .waddr_in(link_we ? idx_r : disc_addr_in),
        .wdata_in(link_we ? rx_byte : disc_wdata_in),
        .raddr_a_in(idx_r),
        .rdata_a_out(mem_a),
        .raddr_b_in(disc_addr_in),
        .rdata_b_out(mem_b)
    );

    // Disc side read data is registered.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            disc_rdata_out <= 8'h00;
        end else begin
            disc_rdata_out <= mem_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-phase byte count, outbound byte and the phase that follows.
    always_comb begin
        last_idx = 8'h00;
        tx_nxt = 8'h00;
        case (phase_r)
            sct_pkg::SCT_PH_CMD: last_idx = `SCT_CMD_LAST;
            sct_pkg::SCT_PH_DIN: begin
                last_idx = `SCT_SECT_LAST;
                tx_nxt = mem_a;
            end
            sct_pkg::SCT_PH_DOUT: last_idx = `SCT_SECT_LAST;
            sct_pkg::SCT_PH_STAT: tx_nxt = status_in;
            sct_pkg::SCT_PH_MSGIN: tx_nxt = `SCT_MSG_DONE;
            default: last_idx = 8'h00;
        endcase
    end

    // Command decides whether a data phase follows.
    always_comb begin
        case (phase_r)
            sct_pkg::SCT_PH_CMD: begin
                if (cmd_op_out == `SCT_OP_READ) begin
                    phase_nxt = sct_pkg::SCT_PH_DIN;
                end else if (cmd_op_out == `SCT_OP_WRITE) begin
                    phase_nxt = sct_pkg::SCT_PH_DOUT;
                end else begin
                    phase_nxt = sct_pkg::SCT_PH_STAT;
                end
            end
            sct_pkg::SCT_PH_DIN: phase_nxt = sct_pkg::SCT_PH_STAT;
            sct_pkg::SCT_PH_DOUT: phase_nxt = sct_pkg::SCT_PH_STAT;
            sct_pkg::SCT_PH_STAT: phase_nxt = sct_pkg::SCT_PH_MSGIN;
            default: phase_nxt = sct_pkg::SCT_PH_CMD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer. A reset seen on the link overrides every state.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= sct_pkg::SCT_T_IDLE;
            phase_r <= sct_pkg::SCT_PH_CMD;
            idx_r <= 8'h00;
            setup_r <= 6'h00;
        end else if (rst_a) begin
            state_r <= sct_pkg::SCT_T_IDLE;
            phase_r <= sct_pkg::SCT_PH_CMD;
            idx_r <= 8'h00;
            setup_r <= 6'h00;
        end else begin
            case (state_r)
                sct_pkg::SCT_T_IDLE: begin
                    if (sel_a && !bsy_a && !io_a) begin
                        state_r <= sct_pkg::SCT_T_SEL;
                    end
                end
                sct_pkg::SCT_T_SEL: begin
                    // Busy holds; start once the initiator lets select go.
                    if (!sel_a) begin
                        state_r <= sct_pkg::SCT_T_SETUP;
                        phase_r <= sct_pkg::SCT_PH_CMD;
                        idx_r <= 8'h00;
                        setup_r <= 6'(`SCT_SETUP_CYC - 1);
                    end
                end
                sct_pkg::SCT_T_SETUP: begin
                    if (setup_r == 6'h00) begin
                        state_r <= sct_pkg::SCT_T_REQ;
                    end else begin
                        setup_r <= setup_r - 6'h01;
                    end
                end
                sct_pkg::SCT_T_REQ: begin
                    if (ack_a) begin
                        state_r <= sct_pkg::SCT_T_REL;
                    end
                end
                sct_pkg::SCT_T_REL: begin
                    // Phase lines may only change after acknowledge drops.
                    if (!ack_a) begin
                        if (idx_r != last_idx) begin
                            idx_r <= idx_r + 8'h01;
                            setup_r <= 6'h00;
                            state_r <= sct_pkg::SCT_T_SETUP;
                        end else if (phase_r == sct_pkg::SCT_PH_MSGIN) begin
                            state_r <= sct_pkg::SCT_T_IDLE;
                        end else begin
                            idx_r <= 8'h00;
                            phase_r <= phase_nxt;
                            setup_r <= 6'(`SCT_SETUP_CYC - 1);
                            state_r <= sct_pkg::SCT_T_SETUP;
                        end
                    end
                end
                default: state_r <= sct_pkg::SCT_T_IDLE;
            endcase
        end
    end

    // Outbound byte is latched during setup so it is stable under request.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_r <= 8'h00;
        end else if (state_r == sct_pkg::SCT_T_SETUP) begin
            tx_r <= tx_nxt;
        end
    end

    // Opcode capture from the first command byte.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_op_out <= 8'h00;
        end else if (state_r == sct_pkg::SCT_T_REQ && ack_a && !rst_a
            && phase_r == sct_pkg::SCT_PH_CMD && idx_r == 8'h00) begin
            cmd_op_out <= rx_byte;
        end
    end

    // Event pulses for the user side.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_valid_out <= 1'b0;
            done_out <= 1'b0;
            bus_reset_out <= 1'b0;
            rst_d_r <= 1'b0;
        end else begin
            cmd_valid_out <= !rst_a && state_r == sct_pkg::SCT_T_REL && !ack_a
                && phase_r == sct_pkg::SCT_PH_CMD && idx_r == `SCT_CMD_LAST;
            done_out <= !rst_a && state_r == sct_pkg::SCT_T_REL && !ack_a
                && phase_r == sct_pkg::SCT_PH_MSGIN;
            rst_d_r <= rst_a;
            bus_reset_out <= rst_a && !rst_d_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line drivers: open collector, so the value is always low and only
    // the enable changes. Released while the link reset is asserted.
    assign link.tgt_ctl_out = 8'h00;
    assign link.tgt_db_out = 8'h00;

    always_comb begin
        link.tgt_ctl_oe = 8'h00;
        if (!rst_a) begin
            link.tgt_ctl_oe[`SCT_BSY] = (state_r != sct_pkg::SCT_T_IDLE);
            link.tgt_ctl_oe[`SCT_REQ] = (state_r == sct_pkg::SCT_T_REQ);
            link.tgt_ctl_oe[`SCT_MSG] = in_xfer && !phase_r[2];
            link.tgt_ctl_oe[`SCT_CD] = in_xfer && !phase_r[1];
            link.tgt_ctl_oe[`SCT_IO] = in_xfer && to_ini;
        end
    end

    // Data is driven only for inbound phases, from request until acknowledge drops.
    assign link.tgt_db_oe = (!rst_a && to_ini && (state_r == sct_pkg::SCT_T_REQ
        || state_r == sct_pkg::SCT_T_REL)) ? tx_r : 8'h00;

    assign busy_out = (state_r != sct_pkg::SCT_T_IDLE);
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "sct_defs.svh"
module tb_top;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    logic rst_req_in = 1'b0;
    logic tx_valid_in = 1'b0;
    logic rx_ready_in = 1'b1;
    logic disc_we_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    logic [7:0] status_in = 8'h00;
    logic [7:0] disc_addr_in = 8'h00;
    logic [7:0] disc_wdata_in = 8'h00;
    logic [7:0] cmd_op_out, disc_rdata_out, rx_data_out;
    logic [2:0] phase_out;
    logic cmd_valid_out, t_busy, t_done, bus_reset_out, disc_ready_out;
    logic tx_ready_out, rx_valid_out, i_busy, i_done;
    logic [7:0] mem_m [256];
    logic [7:0] txq [$];
    logic [10:0] rxq [$];
    int num_errors = 0;
    int checked = 0;
    int n_cmd = 0;
    int n_brst = 0;
    int n_tdone = 0;
    int n_lwr = 0;
    int seed = 32'h782c;

    always #4 mclk_in = ~mclk_in;

    sct_link_if i_sct_link_if ();
    sct_target i_sct_target (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(i_sct_link_if),
        .cmd_op_out(cmd_op_out), .cmd_valid_out(cmd_valid_out), .status_in(status_in), .busy_out(t_busy),
        .done_out(t_done), .bus_reset_out(bus_reset_out), .disc_we_in(disc_we_in), .disc_addr_in(disc_addr_in),
        .disc_wdata_in(disc_wdata_in), .disc_rdata_out(disc_rdata_out), .disc_ready_out(disc_ready_out));
    sct_initiator i_sct_initiator (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(i_sct_link_if),
        .start_in(start_in), .rst_req_in(rst_req_in), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
        .tx_ready_out(tx_ready_out), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .rx_ready_in(rx_ready_in), .phase_out(phase_out), .busy_out(i_busy), .done_out(i_done));
    sct_link_asserts i_sct_link_asserts (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .ctl_n(i_sct_link_if.ctl_n), .tgt_ctl_out(i_sct_link_if.tgt_ctl_out),
        .tgt_ctl_oe(i_sct_link_if.tgt_ctl_oe), .ini_ctl_out(i_sct_link_if.ini_ctl_out),
        .tgt_db_out(i_sct_link_if.tgt_db_out), .tgt_db_oe(i_sct_link_if.tgt_db_oe),
        .ini_db_out(i_sct_link_if.ini_db_out), .ini_db_oe(i_sct_link_if.ini_db_oe));

    ////////////////////////////////////////////////////////////////////////
    // Offer queued bytes and stall the receive side now and then, off the sampling edge.
    always @(negedge mclk_in) begin
        tx_valid_in <= txq.size() > 0;
        tx_data_in <= (txq.size() > 0) ? txq[0] : 8'h00;
        rx_ready_in <= ($random(seed) & 3) != 0;
    end

    // Record received bytes with their phase, and count pulses, at the design's own edge.
    always @(posedge mclk_in) begin
        if (rx_valid_out === 1'b1)
            rxq.push_back({phase_out, rx_data_out});
        if (cmd_valid_out === 1'b1)
            n_cmd++;
        if (bus_reset_out === 1'b1)
            n_brst++;
        if (t_done === 1'b1)
            n_tdone++;
        if (disc_ready_out === 1'b0)
            n_lwr++;
        if (tx_ready_out === 1'b1 && tx_valid_in === 1'b1 && txq.size() > 0)
            void'(txq.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s exp %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait; a hang counts as a mismatch instead of stalling the run.
    task automatic wait_val(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge mclk_in);
            n++;
        end
        chk("wait", v, s);
    endtask

    task automatic begin_cmd(input logic [7:0] op);
        rxq = {};
        txq = {op, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        start_in = 1'b1;
        wait_val(i_busy, 1'b1, 8);
        @(negedge mclk_in);
        start_in = 1'b0;
    endtask

    // One whole command; the model predicts every byte returned with its phase code.
    task automatic run_cmd(input logic [7:0] op);
        logic [10:0] exp_q [$];
        logic [7:0] b;
        int k;
        int n0;
        int d0;
        int w0;
        n0 = n_cmd;
        d0 = n_tdone;
        w0 = n_lwr;
        status_in = 8'($random(seed));
        for (k = 0; k < 256; k++) begin
            b = 8'($random(seed));
            if (op == `SCT_OP_READ)
                exp_q.push_back({sct_pkg::SCT_PH_DIN, mem_m[k]});
            if (op == `SCT_OP_WRITE)
                mem_m[k] = b;
        end
        exp_q.push_back({sct_pkg::SCT_PH_STAT, status_in});
        exp_q.push_back({sct_pkg::SCT_PH_MSGIN, `SCT_MSG_DONE});
        begin_cmd(op);
        if (op == `SCT_OP_WRITE)
            for (k = 0; k < 256; k++)
                txq.push_back(mem_m[k]);
        wait_val(i_done, 1'b1, 8000);
        repeat (2) @(negedge mclk_in);
        chk("opcode", op, cmd_op_out);
        chk("cmd_pulses", n0 + 1, n_cmd);
        chk("tgt_done", d0 + 1, n_tdone);
        chk("link_writes", w0 + ((op == `SCT_OP_WRITE) ? 256 : 0), n_lwr);
        chk("rx_count", exp_q.size(), rxq.size());
        for (k = 0; k < exp_q.size(); k++)
            chk("rx_byte", exp_q[k], rxq[k]);
        chk("bus_free", 8'hff, i_sct_link_if.ctl_n);
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: write a sector, patch it from the disc side, read it back, then reset mid-read.
    initial begin
        int k;
        int nb;
        repeat (21) @(negedge mclk_in);
        reset_n_in = 1'b1;
        wait_val(i_busy, 1'b0, 4000);
        chk("idle_lines", 8'hff, i_sct_link_if.ctl_n);
        run_cmd(`SCT_OP_WRITE);
        for (k = 0; k < 256; k += 17) begin
            disc_addr_in = k[7:0];
            @(negedge mclk_in);
            chk("disc_rd", mem_m[k], disc_rdata_out);
        end
        $display("test write done");
        for (k = 0; k < 4; k++) begin
            disc_we_in = 1'b1;
            disc_addr_in = 8'($random(seed));
            disc_wdata_in = 8'($random(seed));
            mem_m[disc_addr_in] = disc_wdata_in;
            @(negedge mclk_in);
        end
        disc_we_in = 1'b0;
        run_cmd(`SCT_OP_READ);
        $display("test read done");
        begin_cmd(`SCT_OP_READ);
        k = 0;
        while (rxq.size() < 5 && k < 3000) begin
            @(negedge mclk_in);
            k++;
        end
        nb = n_brst;
        rst_req_in = 1'b1;
        @(negedge mclk_in);
        rst_req_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        chk("tgt_busy", 1'b0, t_busy);
        chk("rst_pulse", nb + 1, n_brst);
        wait_val(i_busy, 1'b0, 4000);
        chk("after_rst", 8'hff, i_sct_link_if.ctl_n);
        run_cmd(8'h03);
        $display("test reset done");
        close_out;
    end

    // Watchdog sized at about three times the expected run.
    initial begin
        #(30000 * 8);
        num_errors++;
        $display("FAIL watchdog exp %h seen %h", 1'b1, 1'b0);
        close_out;
    end
endmodule
